// *** shared/clpm_consts.svh ***
// Constants for the copper link power manager: offsets, fields, resets and timing.
`ifndef CLPM_CONSTS_SVH
`define CLPM_CONSTS_SVH
// Clock period and the one-millisecond time base.
`define CLPM_CLK_NS        4
`define CLPM_TICK_NS       1000000
// Register byte offsets.
`define CLPM_OFS_CTRL      8'h00
`define CLPM_OFS_TIMER     8'h04
`define CLPM_OFS_STAT      8'h08
// Control register fields.
`define CLPM_C_DET_EN      0
`define CLPM_C_AN_EN       1
`define CLPM_C_PWR_DN      2
`define CLPM_C_PM_EN       3
`define CLPM_C_LST_HI      4
`define CLPM_C_LST_LO      5
`define CLPM_CTRL_RST      6'h0A
// Timer register fields.
`define CLPM_T_SLEEP       1:0
`define CLPM_T_WAKE        3:2
`define CLPM_TIMER_RST     4'h1
// Status register fields.
`define CLPM_S_DET         1:0
`define CLPM_S_LINK        2
`define CLPM_S_PD_INT      3
`define CLPM_S_PM          5:4
// Detection status codes.
`define CLPM_DET_SEARCH    2'h0
`define CLPM_DET_NEED      2'h1
`define CLPM_DET_NONE      2'h2
// Sleep jitter window and burst spacing, in milliseconds.
`define CLPM_JIT_LO_MS     80
`define CLPM_JIT_HI_MS     60
`define CLPM_JIT_SPAN      141
`define CLPM_BURST_MS      16
`define CLPM_BURST_MAX     2'h3
`define CLPM_LFSR_SEED     16'hACE1
`endif

// *** shared/clpm_pkg.sv ***
// Types shared by the copper link power manager modules.
package clpm_pkg;
  typedef enum logic [1:0] {
    PM_LOW  = 2'b00,
    PM_WAKE = 2'b01,
    PM_NORM = 2'b10
  } clpm_pm_t;
  typedef enum logic [1:0] {
    PD_OFF  = 2'b00,
    PD_SRCH = 2'b01,
    PD_AN   = 2'b10
  } clpm_pd_t;
  // Media side inputs from the analog front end.
  typedef struct packed {
    logic energy;
    logic flp_loop;
  } clpm_media_in_t;
  // Media side controls towards the PHY core.
  typedef struct packed {
    logic core_pwr_dn;
    logic pd_flp;
    logic an_run;
    logic wake_burst;
    logic wake_pair_b;
  } clpm_media_out_t;
  typedef struct packed {
    logic           det_en;
    logic           an_en;
    logic           pwr_dn;
    logic           pm_en;
    logic           lst_hi;
    logic           lst_lo;
    logic [1:0]     sleep_sel;
    logic [1:0]     wake_sel;
    clpm_pd_t       pd;
    logic [1:0]     det_st;
    logic           pd_int;
    logic           pd_link;
    logic [15:0]    pd_cnt;
    clpm_pm_t       pm;
    logic [15:0]    pm_cnt;
    logic [15:0]    sleep_tgt;
    logic [15:0]    lfsr;
    logic [1:0]     burst_n;
    logic           pair_b;
    logic           burst;
    logic           wr_pend;
    logic [7:0]     wr_idx;
    logic [31:0]    rdata;
  } clpm_state_t;
endpackage

// *** rtl/clpm_tick.sv ***
// Millisecond enable pulse divided down from the core clock.
`timescale 1ns/1ps
`include "clpm_consts.svh"
module clpm_tick import clpm_pkg::*; #(
  parameter int TICK_CYCLES = `CLPM_TICK_NS / `CLPM_CLK_NS
) (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  output logic      tick_o
);
  typedef struct packed {
    logic [17:0] cnt;
    logic        tick;
  } clpm_tick_st_t;
  clpm_tick_st_t q, d;

  // Count cycles and emit one pulse per period.
  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt == 18'(TICK_CYCLES - 1)) begin
      d.cnt = 18'h00000;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 18'h00001;
    end
  end

  // State register.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick_o = q.tick;
endmodule

// *** rtl/clpm_sync.sv ***
// Three-stage synchroniser for the media inputs with agreement filter.
`timescale 1ns/1ps
module clpm_sync import clpm_pkg::*; (
  input  wire logic           clk_i,
  input  wire logic           arst_n_i,
  input  clpm_media_in_t      pin_i,
  output clpm_media_in_t      sync_o
);
  typedef struct packed {
    clpm_media_in_t s1;
    clpm_media_in_t s2;
    clpm_media_in_t s3;
    clpm_media_in_t out;
  } clpm_sync_st_t;
  clpm_sync_st_t q, d;

  // Shift each bit along; the output follows once stages two and three agree.
  always_comb begin
    d = q;
    d.s1 = pin_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < $bits(clpm_media_in_t); i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.out[i] = q.s3[i];
      end
    end
  end

  // State register.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_o = q.out;
endmodule

// *** rtl/clpm_top.sv ***
// Copper link power manager: powered-device detection and automatic power-down.
//
// Implementation choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`include "clpm_consts.svh"
module clpm_top import clpm_pkg::*; #(
  parameter int TICK_CYCLES = `CLPM_TICK_NS / `CLPM_CLK_NS,
  parameter int SLEEP_MS0   = 1000,
  parameter int SLEEP_MS1   = 2000,
  parameter int SLEEP_MS2   = 3000,
  parameter int SLEEP_MS3   = 4000,
  parameter int WAKE_MS0    = 40,
  parameter int WAKE_MS1    = 50,
  parameter int WAKE_MS2    = 60,
  parameter int WAKE_MS3    = 80,
  parameter int LST_MS0     = 1000,
  parameter int LST_MS1     = 2000,
  parameter int LST_MS2     = 3000,
  parameter int LST_MS3     = 4000,
  parameter int SEARCH_MS   = 200
) (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  clpm_media_in_t   media_i,
  input  wire logic        link_up_i,
  output clpm_media_out_t  media_o,
  output logic             pd_irq_o
);
  clpm_state_t    q, d;
  clpm_media_in_t med;
  logic           tick;
  logic           acc;
  logic [7:0]     jit;

  // Encodings of the timer fields and the link timeout control bits, in milliseconds.
  function automatic logic [15:0] sleep_ms(input logic [1:0] s);
    case (s)
      2'h0: sleep_ms = 16'(SLEEP_MS0);
      2'h1: sleep_ms = 16'(SLEEP_MS1);
      2'h2: sleep_ms = 16'(SLEEP_MS2);
      default: sleep_ms = 16'(SLEEP_MS3);
    endcase
  endfunction

  function automatic logic [15:0] wake_ms(input logic [1:0] s);
    case (s)
      2'h0: wake_ms = 16'(WAKE_MS0);
      2'h1: wake_ms = 16'(WAKE_MS1);
      2'h2: wake_ms = 16'(WAKE_MS2);
      default: wake_ms = 16'(WAKE_MS3);
    endcase
  endfunction

  function automatic logic [15:0] lst_ms(input logic [1:0] s);
    case (s)
      2'h0: lst_ms = 16'(LST_MS0);
      2'h1: lst_ms = 16'(LST_MS1);
      2'h2: lst_ms = 16'(LST_MS2);
      default: lst_ms = 16'(LST_MS3);
    endcase
  endfunction

  // Jittered sleep target: nominal minus 80 ms plus 0..140 ms.
  function automatic logic [15:0] sleep_target(input logic [1:0] s, input logic [7:0] j);
    sleep_target = sleep_ms(s) - 16'(`CLPM_JIT_LO_MS) + {8'h00, j};
  endfunction

  clpm_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .tick_o   (tick)
  );

  clpm_sync u_sync (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .pin_i    (media_i),
    .sync_o   (med)
  );

  assign acc = hsel_i & hready_i & htrans_i[1];
  assign jit = 8'(q.lfsr[7:0] % 8'(`CLPM_JIT_SPAN));

  // Next-state logic: bus writes, detection, power management, bus reads.
  always_comb begin
    d = q;
    d.burst = 1'b0;
    d.lfsr = {q.lfsr[14:0], q.lfsr[15] ^ q.lfsr[13] ^ q.lfsr[12] ^ q.lfsr[10]};
    // Data phase of a write commits the word.
    if (q.wr_pend) begin
      if (q.wr_idx == `CLPM_OFS_CTRL) begin
        d.det_en = hwdata_i[`CLPM_C_DET_EN];
        d.an_en = hwdata_i[`CLPM_C_AN_EN];
        d.pwr_dn = hwdata_i[`CLPM_C_PWR_DN];
        d.pm_en = hwdata_i[`CLPM_C_PM_EN];
        d.lst_hi = hwdata_i[`CLPM_C_LST_HI];
        d.lst_lo = hwdata_i[`CLPM_C_LST_LO];
      end else if (q.wr_idx == `CLPM_OFS_TIMER) begin
        d.sleep_sel = hwdata_i[`CLPM_T_SLEEP];
        d.wake_sel = hwdata_i[`CLPM_T_WAKE];
      end
    end
    d.wr_pend = acc & hwrite_i;
    d.wr_idx = haddr_i[7:0];
    // Reading the status word clears the interrupt bit; a new event below wins.
    if (acc && !hwrite_i && haddr_i[7:0] == `CLPM_OFS_STAT) begin
      d.pd_int = 1'b0;
    end
    // Powered-device detection, only with auto-negotiation enabled.
    case (q.pd)
      PD_OFF: begin
        if (d.det_en && d.an_en) begin
          d.pd = PD_SRCH;
          d.det_st = `CLPM_DET_SEARCH;
          d.pd_cnt = 16'h0000;
        end
      end
      PD_SRCH: begin
        if (!d.det_en || !d.an_en) begin
          d.pd = PD_OFF;
        end else if (med.flp_loop) begin
          d.det_st = `CLPM_DET_NEED;
          d.pd_int = 1'b1;
          d.pd_cnt = 16'h0000;
        end else if (tick) begin
          if (q.pd_cnt + 16'h0001 >= 16'(SEARCH_MS)) begin
            d.det_st = `CLPM_DET_NONE;
            d.det_en = 1'b0;
            d.pd = PD_AN;
            d.pd_link = 1'b0;
          end else begin
            d.pd_cnt = q.pd_cnt + 16'h0001;
          end
        end
      end
      PD_AN: begin
        if (link_up_i) begin
          d.pd_link = 1'b1;
        end else if (q.pd_link) begin
          d.pd = PD_SRCH;
          d.det_en = 1'b1;
          d.det_st = `CLPM_DET_SEARCH;
          d.pd_cnt = 16'h0000;
        end
      end
      default: begin
        d.pd = PD_OFF;
      end
    endcase
    // Automatic power management.
    if (!d.pm_en) begin
      d.pm = PM_NORM;
      d.pm_cnt = 16'h0000;
    end else begin
      case (q.pm)
        PM_LOW: begin
          if (med.energy) begin
            d.pm = PM_NORM;
            d.pm_cnt = 16'h0000;
          end else if (tick) begin
            if (q.pm_cnt + 16'h0001 >= q.sleep_tgt) begin
              d.pm = PM_WAKE;
              d.pm_cnt = 16'h0000;
              d.burst = 1'b1;
              d.burst_n = 2'h1;
              d.pair_b = ~q.pair_b;
            end else begin
              d.pm_cnt = q.pm_cnt + 16'h0001;
            end
          end
        end
        PM_WAKE: begin
          if (med.energy) begin
            d.pm = PM_NORM;
            d.pm_cnt = 16'h0000;
          end else if (tick) begin
            d.pm_cnt = q.pm_cnt + 16'h0001;
            if (q.pm_cnt + 16'h0001 >= wake_ms(q.wake_sel)) begin
              d.pm = PM_LOW;
              d.pm_cnt = 16'h0000;
              d.sleep_tgt = sleep_target(q.sleep_sel, jit);
            end else if (q.burst_n < `CLPM_BURST_MAX &&
                         q.pm_cnt + 16'h0001 == 16'(q.burst_n) * 16'(`CLPM_BURST_MS)) begin
              d.burst = 1'b1;
              d.burst_n = q.burst_n + 2'h1;
              d.pair_b = ~q.pair_b;
            end
          end
        end
        PM_NORM: begin
          if (!q.an_en || link_up_i) begin
            d.pm_cnt = 16'h0000;
          end else if (tick) begin
            if (q.pm_cnt + 16'h0001 >= lst_ms({q.lst_hi, q.lst_lo})) begin
              d.pm = PM_LOW;
              d.pm_cnt = 16'h0000;
              d.sleep_tgt = sleep_target(q.sleep_sel, jit);
            end else begin
              d.pm_cnt = q.pm_cnt + 16'h0001;
            end
          end
        end
        default: begin
          d.pm = PM_LOW;
        end
      endcase
    end
    // Address phase of a read loads the answer for the data phase.
    d.rdata = 32'h00000000;
    if (acc && !hwrite_i) begin
      if (haddr_i[7:0] == `CLPM_OFS_CTRL) begin
        d.rdata[`CLPM_C_DET_EN] = d.det_en;
        d.rdata[`CLPM_C_AN_EN] = d.an_en;
        d.rdata[`CLPM_C_PWR_DN] = d.pwr_dn;
        d.rdata[`CLPM_C_PM_EN] = d.pm_en;
        d.rdata[`CLPM_C_LST_HI] = d.lst_hi;
        d.rdata[`CLPM_C_LST_LO] = d.lst_lo;
      end else if (haddr_i[7:0] == `CLPM_OFS_TIMER) begin
        d.rdata[`CLPM_T_SLEEP] = d.sleep_sel;
        d.rdata[`CLPM_T_WAKE] = d.wake_sel;
      end else if (haddr_i[7:0] == `CLPM_OFS_STAT) begin
        d.rdata[`CLPM_S_DET] = q.det_st;
        d.rdata[`CLPM_S_LINK] = link_up_i;
        d.rdata[`CLPM_S_PD_INT] = q.pd_int;
        d.rdata[`CLPM_S_PM] = q.pm;
      end
    end
  end

  // State register; power management starts in the low-power state.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
      {q.lst_lo, q.lst_hi, q.pm_en, q.pwr_dn, q.an_en, q.det_en} <= `CLPM_CTRL_RST;
      {q.wake_sel, q.sleep_sel} <= `CLPM_TIMER_RST;
      q.pm <= PM_LOW;
      q.pd <= PD_OFF;
      q.sleep_tgt <= 16'(SLEEP_MS1);
      q.lfsr <= `CLPM_LFSR_SEED;
    end else begin
      q <= d;
    end
  end

  // Bus answers and media controls; the core sleeps in low power or power-down.
  assign hrdata_o = q.rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign pd_irq_o = q.pd_int;
  assign media_o.core_pwr_dn = q.pwr_dn | (q.pm == PM_LOW);
  assign media_o.pd_flp = (q.pd == PD_SRCH) & ~q.pwr_dn;
  assign media_o.an_run = q.an_en & (q.pd != PD_SRCH) & ~media_o.core_pwr_dn;
  assign media_o.wake_burst = q.burst;
  assign media_o.wake_pair_b = q.pair_b;

  // Checks of the detection sequence.
  search_code_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (q.pd == PD_SRCH) |-> (q.det_st != `CLPM_DET_NONE))
    else $error("search shows status 10");
  loop_need_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (q.pd == PD_SRCH && med.flp_loop && q.det_en && q.an_en && !q.wr_pend)
      |=> (q.det_st == `CLPM_DET_NEED) && pd_irq_o)
    else $error("loopback did not give status 01");
  int_clear_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (acc && !hwrite_i && haddr_i[7:0] == `CLPM_OFS_STAT && (q.pd != PD_SRCH || !med.flp_loop))
      |=> !pd_irq_o)
    else $error("status read left interrupt set");
  timeout_none_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (q.pd == PD_SRCH && tick && !med.flp_loop && q.det_en && q.an_en && !q.wr_pend
      && q.pd_cnt == 16'(SEARCH_MS - 1))
      |=> (q.det_st == `CLPM_DET_NONE) && !q.det_en && q.pd == PD_AN)
    else $error("search limit did not give status 10");
  link_fail_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (q.pd == PD_AN && q.pd_link && !link_up_i) |=> (q.pd == PD_SRCH) && q.det_en)
    else $error("link failure did not resume detection");

  // Checks of the power-management sequence.
  energy_wake_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (q.pm_en && !q.wr_pend && q.pm != PM_NORM && med.energy) |=> (q.pm == PM_NORM))
    else $error("energy did not enter normal state");
  forced_stay_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (q.pm == PM_NORM && !q.an_en && !q.wr_pend) |=> (q.pm == PM_NORM))
    else $error("forced mode left normal state");
  low_power_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (q.pm == PM_LOW) |-> media_o.core_pwr_dn && !media_o.an_run && !q.burst)
    else $error("low power state left core running");
  pwr_bit_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (q.wr_pend && q.wr_idx == `CLPM_OFS_CTRL && hwdata_i[`CLPM_C_PWR_DN])
      |=> media_o.core_pwr_dn)
    else $error("power-down bit not honoured");
  sleep_range_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (d.pm == PM_LOW && q.pm != PM_LOW)
      |-> (int'(d.sleep_tgt) + `CLPM_JIT_LO_MS >= int'(sleep_ms(q.sleep_sel)))
       && (int'(d.sleep_tgt) <= int'(sleep_ms(q.sleep_sel)) + `CLPM_JIT_HI_MS))
    else $error("sleep target outside jitter window");
  burst_pair_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    q.burst |-> (q.pm == PM_WAKE) && (q.burst_n != 2'h0) && (q.pair_b != $past(q.pair_b)))
    else $error("burst outside wake-up or pair not alternated");
endmodule

// *** dv/clpm_partner.sv ***
// Link partner model on the cable: echoes search pulses and answers wake bursts.
`timescale 1ns/1ps
module clpm_partner import clpm_pkg::*; (
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  clpm_media_out_t phy_i,
  input  wire logic       loop_en_i,
  input  wire logic       wake_en_i,
  input  wire logic       plug_i,
  input  wire logic       link_en_i,
  output clpm_media_in_t  line_o,
  output logic            link_up_o
);
  logic [4:0] ph_q;
  logic       woke_q;

  // Free phase counter and the latch that records a wake burst reaching us.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ph_q   <= 5'h00;
      woke_q <= 1'b0;
    end else begin
      ph_q   <= ph_q + 5'h01;
      woke_q <= (woke_q | phy_i.wake_burst) & wake_en_i;
    end
  end

  // An unpowered device echoes pulses for 6 of every 32 cycles, so it answers slowly.
  assign line_o.flp_loop = loop_en_i & phy_i.pd_flp & (ph_q < 5'h06);
  // Energy appears once plugged in or once woken by a burst.
  assign line_o.energy   = plug_i | woke_q;
  assign link_up_o       = link_en_i;
endmodule

// *** dv/clpm_top_test.sv ***
// Self-checking bench for the copper link power manager.
`timescale 1ns/1ps
`include "clpm_consts.svh"
module clpm_top_test import clpm_pkg::*;;
  localparam int          TK  = 20;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  // Sleep and wake times per timer select, in milliseconds; sleep select 01 and wake select 00 are the reset choices.
  localparam int          SL[4] = '{100, 200, 150, 250};
  localparam int          WK[4] = '{40, 50, 60, 80};
  typedef struct {
    string       nm;
    logic [31:0] exp;
    logic [31:0] msk;
  } clpm_note_t;
  logic            clk_i    = 1'b0;
  logic            arst_n_i = 1'b0;
  logic            hsel_i;
  logic            hwrite_i;
  logic [1:0]      htrans_i;
  logic [2:0]      hsize_i;
  logic [31:0]     haddr_i;
  logic [31:0]     hwdata_i;
  logic [31:0]     hrdata_o;
  logic            hreadyout_o;
  logic            hresp_o;
  logic            pd_irq_o;
  logic            link_up_i;
  clpm_media_in_t  media_i;
  clpm_media_out_t media_o;
  logic            loop_en, wake_en, plug, link_en, rd_ph, port_pwr, alt, pb;
  int              mismatches, total_checks, seed, t0, n, nb, lst, ts, sl, wk;
  int              cyc = 0;
  clpm_note_t      notes[$];
  clpm_note_t      note;

  always #2 clk_i = ~clk_i;

  clpm_top #(.TICK_CYCLES(TK), .SLEEP_MS0(SL[0]), .SLEEP_MS1(SL[1]), .SLEEP_MS2(SL[2]),
             .SLEEP_MS3(SL[3]), .WAKE_MS0(WK[0]), .WAKE_MS1(WK[1]), .WAKE_MS2(WK[2]),
             .WAKE_MS3(WK[3]), .LST_MS0(4), .LST_MS1(6), .LST_MS2(8), .LST_MS3(10),
             .SEARCH_MS(10)) dut (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .media_i(media_i), .link_up_i(link_up_i), .media_o(media_o),
    .pd_irq_o(pd_irq_o));

  clpm_partner peer (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .phy_i(media_o), .loop_en_i(loop_en & ~port_pwr),
    .wake_en_i(wake_en), .plug_i(plug), .link_en_i(link_en), .line_o(media_i),
    .link_up_o(link_up_i));

  // Compares a seen value with the expected one and counts both outcomes.
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [31:0] inr(int v, int lo, int hi);
    return {31'h0, (v >= lo) && (v <= hi)};
  endfunction

  // One AHB-Lite single transfer; a read leaves its expectation in the queue.
  task automatic bus(logic [7:0] a, logic wr, logic [31:0] d, logic [31:0] msk, string nm);
    hsel_i   <= 1'b1;
    hsize_i  <= 3'h2;
    htrans_i <= 2'h2;
    haddr_i  <= {24'h000000, a};
    hwrite_i <= wr;
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_i);
    // Select and size wander while no transfer is requested.
    hsel_i   <= 1'($random(seed));
    hsize_i  <= 3'($random(seed));
    htrans_i <= 2'h0;
    hwdata_i <= d;
    if (!wr) begin
      notes.push_back('{nm, d, msk});
      rd_ph <= 1'b1;
    end
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_i);
    rd_ph <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] exp, logic [31:0] msk, string nm);
    bus(a, 1'b0, exp, msk, nm);
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    bus(a, 1'b1, d, ALL, "");
  endtask

  // Counts cycles until the core power-down output reaches the given level.
  task automatic wait_pd(logic v, int lim);
    for (n = 0; n < lim && media_o.core_pwr_dn !== v; n++) @(posedge clk_i);
  endtask

  task automatic end_of_test();
    $display("Checks made %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Read data watcher: takes the oldest note whenever a read data phase completes.
  always @(posedge clk_i) begin
    if (rd_ph === 1'b1 && hreadyout_o === 1'b1) begin
      note = notes.pop_front();
      check(note.nm, hrdata_o & note.msk, note.exp);
    end
  end

  // Cuts a hang short.
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    seed = 2;
    mismatches = 0;
    total_checks = 0;
    hsel_i = 1'b1;
    hsize_i = 3'h2;
    htrans_i = 2'h0;
    haddr_i = 32'h0;
    hwrite_i = 1'b0;
    hwdata_i = 32'h0;
    rd_ph = 1'b0;
    {loop_en, wake_en, plug, link_en, port_pwr} = 5'h00;
    repeat (8) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t0 = cyc;
    @(posedge clk_i);
    // Reset values, reserved bits and an unmapped word.
    check("core_pwr_dn", media_o.core_pwr_dn, 32'h1);
    rd(`CLPM_OFS_CTRL, 32'h0A, ALL, "ctrl");
    rd(`CLPM_OFS_STAT, 32'h00, 32'h30, "pm state");
    rd(8'h0C, 32'h0, ALL, "unmapped");
    ts = $random(seed) & 15;
    sl = SL[ts[1:0]];
    wk = WK[ts[3:2]];
    wr(`CLPM_OFS_TIMER, ts | ($random(seed) & 32'hFFFFFFF0));
    rd(`CLPM_OFS_TIMER, ts, ALL, "timer");
    $display("Test reset finished");
    // Sleep for the reset target of select 01, then bursts on alternating pairs for the wake time.
    for (n = 0; n < 300 * TK && media_o.wake_burst !== 1'b1; n++) @(posedge clk_i);
    check("sleep time", inr(cyc - t0, 119 * TK, 262 * TK), 32'h1);
    nb = 0;
    alt = 1'b1;
    pb = ~media_o.wake_pair_b;
    for (n = 0; n < 90 * TK && media_o.core_pwr_dn !== 1'b1; n++) begin
      if (media_o.wake_burst === 1'b1) begin
        nb++;
        alt = alt & (media_o.wake_pair_b !== pb);
        pb = media_o.wake_pair_b;
      end
      @(posedge clk_i);
    end
    check("burst count", nb, 32'h3);
    check("pair alternation", alt, 32'h1);
    check("wake time", inr(n, (wk - 1) * TK, (wk + 2) * TK), 32'h1);
    rd(`CLPM_OFS_STAT, 32'h00, 32'h30, "pm back low");
    $display("Test sleep and wake finished");
    // A burst that wakes the partner brings energy and the normal state.
    wake_en <= 1'b1;
    wait_pd(1'b0, 340 * TK);
    check("jittered sleep", inr(n, (sl - 81) * TK, (sl + 60) * TK), 32'h1);
    repeat (20) @(posedge clk_i);
    rd(`CLPM_OFS_STAT, 32'h20, 32'h30, "pm normal");
    // Each link timeout choice, measured from link loss to low power.
    for (int i = 0; i < 4; i++) begin
      lst = 4 + 2 * i;
      wr(`CLPM_OFS_CTRL, {26'h0, i[0], i[1], 4'hA});
      plug <= 1'b1;
      wait_pd(1'b0, 50);
      link_en <= 1'b1;
      repeat (16 + ($random(seed) & 15)) @(posedge clk_i);
      {link_en, plug, wake_en} <= 3'h0;
      wait_pd(1'b1, 20 * TK);
      check("link timeout", inr(n, (lst - 1) * TK, (lst + 1) * TK + 8), 32'h1);
    end
    $display("Test link timeout finished");
    // Detection with management off, which forces the normal state.
    wr(`CLPM_OFS_CTRL, 32'h03);
    repeat (3) @(posedge clk_i);
    check("core_pwr_dn", media_o.core_pwr_dn, 32'h0);
    check("pd_flp", media_o.pd_flp, 32'h1);
    rd(`CLPM_OFS_STAT, 32'h20, 32'h33, "searching");
    loop_en <= 1'b1;
    for (n = 0; n < 100 && pd_irq_o !== 1'b1; n++) @(posedge clk_i);
    // A powered partner stops echoing; let the last echo drain through the synchroniser.
    port_pwr <= 1'b1;
    check("pd_irq", pd_irq_o, 32'h1);
    repeat (10) @(posedge clk_i);
    rd(`CLPM_OFS_STAT, 32'h09, 32'h0B, "needs power");
    repeat (2) @(posedge clk_i);
    check("pd_irq cleared", pd_irq_o, 32'h0);
    rd(`CLPM_OFS_STAT, 32'h01, 32'h0B, "int cleared");
    for (n = 0; n < 14 * TK && media_o.pd_flp !== 1'b0; n++) @(posedge clk_i);
    check("search limit", inr(n, 8 * TK, 13 * TK), 32'h1);
    repeat (2) @(posedge clk_i);
    check("an_run", media_o.an_run, 32'h1);
    rd(`CLPM_OFS_STAT, 32'h02, 32'h03, "none found");
    rd(`CLPM_OFS_CTRL, 32'h0, 32'h1, "det_en off");
    link_en <= 1'b1;
    repeat (4) @(posedge clk_i);
    rd(`CLPM_OFS_STAT, 32'h06, 32'h07, "link up");
    link_en <= 1'b0;
    {loop_en, port_pwr} <= 2'b00;
    for (n = 0; n < 20 && media_o.pd_flp !== 1'b1; n++) @(posedge clk_i);
    repeat (2) @(posedge clk_i);
    check("pd_flp again", media_o.pd_flp, 32'h1);
    check("an_run stopped", media_o.an_run, 32'h0);
    rd(`CLPM_OFS_STAT, 32'h00, 32'h03, "search again");
    rd(`CLPM_OFS_CTRL, 32'h1, 32'h1, "det_en back");
    $display("Test detection finished");
    // Forced mode keeps the normal state; the power-down bit acts on its own.
    wr(`CLPM_OFS_CTRL, 32'h08);
    link_en <= 1'b1;
    repeat (10) @(posedge clk_i);
    link_en <= 1'b0;
    repeat (13 * TK) @(posedge clk_i);
    check("forced stays up", media_o.core_pwr_dn, 32'h0);
    rd(`CLPM_OFS_STAT, 32'h20, 32'h30, "forced normal");
    wr(`CLPM_OFS_CTRL, 32'h0C);
    repeat (3) @(posedge clk_i);
    check("power down bit", media_o.core_pwr_dn, 32'h1);
    rd(`CLPM_OFS_STAT, 32'h20, 32'h30, "state kept");
    $display("Test forced mode finished");
    end_of_test();
  end
endmodule
